// File: verilog/spmux_pkg.sv
// Shared types and constants for the serial port pin multiplexer
package spmux_pkg;

   // One serial port's clock and frame pins, in this bit order
   typedef struct packed {
      logic rx_clock;
      logic tx_clock;
      logic rx_frame_sync;
      logic tx_frame_sync;
   } spmux_ctl_type;

   // Emulation and test pins that decide OFF mode
   typedef struct packed {
      logic test_resetn;
      logic emu_zero;
      logic emu_one_off;
   } spmux_emu_type;

   // Function of the shared port 2 pins, fixed at reset release
   typedef enum logic {
      SPMUX_UART_GPIO,
      SPMUX_PORT2
   } spmux_func_type;

   // Strap latch phase after reset
   typedef enum logic {
      SPMUX_PH_LATCH,
      SPMUX_PH_RUN
   } spmux_phase_type;

   localparam int NUM_PORTS = 3;
   localparam int NUM_SHARED = 4;
   // Shared pin positions
   localparam int SP_IDX_ZERO = 0;
   localparam int SP_IDX_ONE = 1;
   localparam int SP_IDX_TWO = 2;
   localparam int SP_IDX_THREE = 3;
   // Pins that float in OFF mode; port 1 receive clock does not
   localparam logic [3:0] OFF_CTL_PORT0 = 4'hf;
   localparam logic [3:0] OFF_CTL_PORT1 = 4'h7;
   localparam logic [2:0] OFF_TX_DATA = 3'h7;
   localparam logic [3:0] OFF_SHARED = 4'hf;
   // Reset values
   localparam logic [3:0] RST_SHARED_OUT = 4'h2;
   localparam logic UART_IDLE = 1'b1;
   localparam spmux_func_type RST_FUNC = SPMUX_UART_GPIO;

endpackage

// File: verilog/spmux_top.sv
// Pin multiplexer and reset pin states for the three serial ports
//
// Behaviour
// [RULE1] Shared pin zero: general pin three or tx clock
// [RULE2] Shared pin one: UART transmit or rx clock
// [RULE3] Shared pin two: general pin five or tx sync
// [RULE4] Function fixed at reset release from strap
// [RULE5] UART transmit drives one around reset; code sets its value to one but leaves it undriven until run
// [RULE6] Transmit data pins float until configured
// [RULE7] Port 0/1 clocks are inputs after reset
// [RULE8] Port 0/1 frame syncs inputs after reset
// [RULE9] General pins three, five start as inputs
// [RULE10] Port 2 clock and sync pins start inputs
// [RULE11] OFF mode pins float in emulation off; code floats all but the port 1 receive clock
// [RULE12] Reset tristate pins float during reset
// [RULE13] Port pins usable as general purpose
// [RULE14] Shared pin three: UART receive or rx sync
// [RULE15] Latched strap never changes after release
`timescale 1ns/1ps

module spmux_top (
   input wire logic clk,
   input wire logic resetn,
   input wire logic serial_config_strap,
   input wire spmux_pkg::spmux_emu_type emu_pins,
   input wire spmux_pkg::spmux_ctl_type [1:0] port_ctl_in,
   output spmux_pkg::spmux_ctl_type [1:0] port_ctl_out,
   output spmux_pkg::spmux_ctl_type [1:0] port_ctl_oe,
   output logic [2:0] port_tx_data_out,
   output logic [2:0] port_tx_data_oe,
   input wire logic [2:0] port_rx_data_in,
   input wire logic [3:0] shared_pin_in,
   output logic [3:0] shared_pin_out,
   output logic [3:0] shared_pin_oe,
   input wire spmux_pkg::spmux_ctl_type [2:0] eng_ctl_out,
   input wire spmux_pkg::spmux_ctl_type [2:0] eng_ctl_oe,
   output spmux_pkg::spmux_ctl_type [2:0] eng_ctl_in,
   input wire logic [2:0] eng_tx_data,
   input wire logic [2:0] eng_tx_data_en,
   output logic [2:0] eng_rx_data,
   input wire spmux_pkg::spmux_ctl_type [2:0] gp_ctl_sel,
   input wire spmux_pkg::spmux_ctl_type [2:0] gp_ctl_out,
   input wire spmux_pkg::spmux_ctl_type [2:0] gp_ctl_oe,
   input wire logic [2:0] gp_tx_data_sel,
   input wire logic [2:0] gp_tx_data_out,
   input wire logic [2:0] gp_tx_data_oe,
   input wire logic general_pin_three_out,
   input wire logic general_pin_three_oe,
   output logic general_pin_three_in,
   input wire logic general_pin_five_out,
   input wire logic general_pin_five_oe,
   output logic general_pin_five_in,
   input wire logic uart_tx_value,
   output logic uart_rx_value,
   output logic port2_selected
);

   localparam int ASYNC_W = 18;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [ASYNC_W-1:0] async_w;
   logic [ASYNC_W-1:0] meta_r;
   logic [ASYNC_W-1:0] meta_nxt;
   logic [ASYNC_W-1:0] sync_r;
   logic [ASYNC_W-1:0] sync_nxt;
   logic strap_meta_r;
   logic strap_sync_r;
   spmux_pkg::spmux_ctl_type [1:0] ctl_sync_w;
   logic [3:0] sp_sync_w;
   logic [2:0] dr_sync_w;
   spmux_pkg::spmux_emu_type emu_sync_w;
   logic off_w;

   assign async_w = {emu_pins, port_rx_data_in, shared_pin_in, port_ctl_in};

   // Second stage reads the first; only the second feeds logic
   always_comb begin
      meta_nxt = async_w;
      sync_nxt = meta_r;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   // Strap chain has no reset so it keeps sampling while reset is low
   always_ff @(posedge clk) begin
      strap_meta_r <= serial_config_strap;
      strap_sync_r <= strap_meta_r;
   end

   assign ctl_sync_w = sync_r[7:0];
   assign sp_sync_w = sync_r[11:8];
   assign dr_sync_w = sync_r[14:12];
   assign emu_sync_w = sync_r[17:15];
   // Synced zeros after reset mean OFF mode is never entered falsely
   assign off_w = ~emu_sync_w.test_resetn & emu_sync_w.emu_zero & ~emu_sync_w.emu_one_off; // [RULE11]

   ////////////////////////////////////////////////////////////////////////////
   // Strap latch at reset release

   spmux_pkg::spmux_phase_type phase_r;
   spmux_pkg::spmux_phase_type phase_nxt;
   spmux_pkg::spmux_func_type func_r;
   spmux_pkg::spmux_func_type func_nxt;
   logic run_w;

   // First edge after release takes the strap level seen during reset
   always_comb begin
      phase_nxt = phase_r;
      func_nxt = func_r;
      case (phase_r)
         spmux_pkg::SPMUX_PH_LATCH: begin
            func_nxt = strap_sync_r ? spmux_pkg::SPMUX_PORT2 : spmux_pkg::SPMUX_UART_GPIO; // [RULE4]
            phase_nxt = spmux_pkg::SPMUX_PH_RUN;
         end
         spmux_pkg::SPMUX_PH_RUN: begin
            func_nxt = func_r; // [RULE15]
         end
         default: begin
            phase_nxt = spmux_pkg::SPMUX_PH_LATCH;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         phase_r <= spmux_pkg::SPMUX_PH_LATCH;
         func_r <= spmux_pkg::RST_FUNC;
      end else begin
         phase_r <= phase_nxt;
         func_r <= func_nxt;
      end
   end

   assign run_w = (phase_r == spmux_pkg::SPMUX_PH_RUN);
   assign port2_selected = (func_r == spmux_pkg::SPMUX_PORT2);

   ////////////////////////////////////////////////////////////////////////////
   // Per-port engine or general purpose selection

   spmux_pkg::spmux_ctl_type [2:0] mux_out_w;
   spmux_pkg::spmux_ctl_type [2:0] mux_oe_w;
   logic [2:0] dx_out_w;
   logic [2:0] dx_oe_w;

   // Software may hand any clock, sync or transmit data pin to general purpose use
   for (genvar p = 0; p < spmux_pkg::NUM_PORTS; p++) begin : g_port
      assign mux_out_w[p] = (gp_ctl_sel[p] & gp_ctl_out[p]) | (~gp_ctl_sel[p] & eng_ctl_out[p]); // [RULE13]
      assign mux_oe_w[p] = (gp_ctl_sel[p] & gp_ctl_oe[p]) | (~gp_ctl_sel[p] & eng_ctl_oe[p]); // [RULE13]
      assign dx_out_w[p] = gp_tx_data_sel[p] ? gp_tx_data_out[p] : eng_tx_data[p];
      assign dx_oe_w[p] = gp_tx_data_sel[p] ? gp_tx_data_oe[p] : eng_tx_data_en[p]; // [RULE6]
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers

   spmux_pkg::spmux_ctl_type [1:0] ctl_out_nxt;
   spmux_pkg::spmux_ctl_type [1:0] ctl_oe_nxt;
   logic [2:0] dx_out_nxt;
   logic [2:0] dx_oe_nxt;
   logic [3:0] sp_out_nxt;
   logic [3:0] sp_oe_nxt;
   logic [3:0] sp_oe_raw;

   // Every enable is held low in the latch cycle so all pins start as inputs
   always_comb begin
      ctl_out_nxt = mux_out_w[1:0];
      ctl_oe_nxt[0] = mux_oe_w[0] & ~({4{off_w}} & spmux_pkg::OFF_CTL_PORT0) & {4{run_w}}; // [RULE7]
      ctl_oe_nxt[1] = mux_oe_w[1] & ~({4{off_w}} & spmux_pkg::OFF_CTL_PORT1) & {4{run_w}}; // [RULE8]
      dx_out_nxt = dx_out_w;
      dx_oe_nxt = dx_oe_w & ~({3{off_w}} & spmux_pkg::OFF_TX_DATA) & {3{run_w}}; // [RULE6]
      sp_out_nxt = spmux_pkg::RST_SHARED_OUT;
      sp_oe_raw = '0;
      case (func_r)
         spmux_pkg::SPMUX_PORT2: begin
            sp_out_nxt[spmux_pkg::SP_IDX_ZERO] = mux_out_w[2].tx_clock; // [RULE1]
            sp_out_nxt[spmux_pkg::SP_IDX_ONE] = mux_out_w[2].rx_clock; // [RULE2]
            sp_out_nxt[spmux_pkg::SP_IDX_TWO] = mux_out_w[2].tx_frame_sync; // [RULE3]
            sp_out_nxt[spmux_pkg::SP_IDX_THREE] = mux_out_w[2].rx_frame_sync; // [RULE14]
            sp_oe_raw[spmux_pkg::SP_IDX_ZERO] = mux_oe_w[2].tx_clock; // [RULE10]
            sp_oe_raw[spmux_pkg::SP_IDX_ONE] = mux_oe_w[2].rx_clock; // [RULE10]
            sp_oe_raw[spmux_pkg::SP_IDX_TWO] = mux_oe_w[2].tx_frame_sync; // [RULE10]
            sp_oe_raw[spmux_pkg::SP_IDX_THREE] = mux_oe_w[2].rx_frame_sync; // [RULE10]
         end
         spmux_pkg::SPMUX_UART_GPIO: begin
            sp_out_nxt[spmux_pkg::SP_IDX_ZERO] = general_pin_three_out; // [RULE1]
            sp_out_nxt[spmux_pkg::SP_IDX_ONE] = run_w ? uart_tx_value : spmux_pkg::UART_IDLE; // [RULE5]
            sp_out_nxt[spmux_pkg::SP_IDX_TWO] = general_pin_five_out; // [RULE3]
            sp_oe_raw[spmux_pkg::SP_IDX_ZERO] = general_pin_three_oe; // [RULE9]
            sp_oe_raw[spmux_pkg::SP_IDX_ONE] = 1'b1; // [RULE2]
            sp_oe_raw[spmux_pkg::SP_IDX_TWO] = general_pin_five_oe; // [RULE9]
            sp_oe_raw[spmux_pkg::SP_IDX_THREE] = 1'b0; // [RULE14]
         end
         default: begin
            sp_oe_raw = '0;
         end
      endcase
      sp_oe_nxt = sp_oe_raw & ~({4{off_w}} & spmux_pkg::OFF_SHARED) & {4{run_w}}; // [RULE11]
   end

   // Asynchronous reset floats every driven pin while reset is low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         port_ctl_out <= '0;
         port_ctl_oe <= '0; // [RULE12]
         port_tx_data_out <= '0;
         port_tx_data_oe <= '0; // [RULE12]
         shared_pin_out <= spmux_pkg::RST_SHARED_OUT; // [RULE5]
         shared_pin_oe <= '0; // [RULE12]
      end else begin
         port_ctl_out <= ctl_out_nxt;
         port_ctl_oe <= ctl_oe_nxt;
         port_tx_data_out <= dx_out_nxt;
         port_tx_data_oe <= dx_oe_nxt;
         shared_pin_out <= sp_out_nxt;
         shared_pin_oe <= sp_oe_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Inputs returned to the engines

   spmux_pkg::spmux_ctl_type [2:0] eng_in_nxt;
   logic gp3_in_nxt;
   logic gp5_in_nxt;
   logic urx_nxt;
   logic port2_w;

   assign port2_w = (func_r == spmux_pkg::SPMUX_PORT2);

   // Deselected functions see a quiet level: zero, or idle high for UART
   always_comb begin
      eng_in_nxt[1:0] = ctl_sync_w;
      eng_in_nxt[2] = '0;
      gp3_in_nxt = 1'b0;
      gp5_in_nxt = 1'b0;
      urx_nxt = spmux_pkg::UART_IDLE;
      if (port2_w) begin
         eng_in_nxt[2].tx_clock = sp_sync_w[spmux_pkg::SP_IDX_ZERO];
         eng_in_nxt[2].rx_clock = sp_sync_w[spmux_pkg::SP_IDX_ONE];
         eng_in_nxt[2].tx_frame_sync = sp_sync_w[spmux_pkg::SP_IDX_TWO];
         eng_in_nxt[2].rx_frame_sync = sp_sync_w[spmux_pkg::SP_IDX_THREE]; // [RULE14]
      end else begin
         gp3_in_nxt = sp_sync_w[spmux_pkg::SP_IDX_ZERO];
         gp5_in_nxt = sp_sync_w[spmux_pkg::SP_IDX_TWO];
         urx_nxt = sp_sync_w[spmux_pkg::SP_IDX_THREE]; // [RULE14]
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         eng_ctl_in <= '0;
         eng_rx_data <= '0;
         general_pin_three_in <= 1'b0;
         general_pin_five_in <= 1'b0;
         uart_rx_value <= spmux_pkg::UART_IDLE;
      end else begin
         eng_ctl_in <= eng_in_nxt;
         eng_rx_data <= dr_sync_w;
         general_pin_three_in <= gp3_in_nxt;
         general_pin_five_in <= gp5_in_nxt;
         uart_rx_value <= urx_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_strap_latch_value: assert property ( // [RULE4]
      (phase_r == spmux_pkg::SPMUX_PH_LATCH) |=> (port2_selected == $past(strap_sync_r)))
      else $error("function not taken from strap");

   a_strap_held_run: assert property ( // [RULE15]
      run_w && $past(run_w) |-> $stable(func_r))
      else $error("function changed after release");

   a_first_cycles_input: assert property ( // [RULE7]
      $rose(run_w) |-> (port_ctl_oe == '0) && (shared_pin_oe == '0))
      else $error("pin driven before release settled");

   a_tx_data_float: assert property ( // [RULE6]
      !eng_tx_data_en[0] && !gp_tx_data_sel[0] |=> !port_tx_data_oe[0])
      else $error("tx data driven without enable");

   a_uart_tx_drive: assert property ( // [RULE2]
      run_w && !port2_w && !off_w |=> shared_pin_oe[1] && (shared_pin_out[1] == $past(uart_tx_value)))
      else $error("UART transmit not driven");

   a_uart_rx_input: assert property ( // [RULE14]
      !port2_w |=> !shared_pin_oe[3])
      else $error("UART receive pin driven");

   a_port2_clock_pin: assert property ( // [RULE1]
      run_w && port2_w && !off_w && !gp_ctl_sel[2].tx_clock |=>
         shared_pin_oe[0] == $past(eng_ctl_oe[2].tx_clock))
      else $error("shared pin zero not port 2 tx clock");

   a_general_pin_five_pin: assert property ( // [RULE3]
      run_w && !port2_w && !off_w |=> shared_pin_oe[2] == $past(general_pin_five_oe))
      else $error("shared pin two not general pin five");

   a_off_mode_float: assert property ( // [RULE11]
      off_w |=> (shared_pin_oe == '0) && (port_tx_data_oe == '0) && (port_ctl_oe[0] == '0))
      else $error("pin driven in OFF mode");

   a_gp_output: assert property ( // [RULE13]
      run_w && !off_w && gp_ctl_sel[0].rx_clock && gp_ctl_oe[0].rx_clock |=>
         port_ctl_oe[0].rx_clock && (port_ctl_out[0].rx_clock == $past(gp_ctl_out[0].rx_clock)))
      else $error("general purpose output not driven");

   a_reset_float: assert property (@(posedge clk) disable iff (1'b0) // [RULE12]
      !resetn |-> (shared_pin_oe == '0) && (port_ctl_oe == '0) && (port_tx_data_oe == '0))
      else $error("pin driven during reset");

endmodule // spmux_top

// File: verif/spmux_board.sv
// Board model at the pins: resolves each two-way pin from both drivers
`timescale 1ns/1ps

module spmux_board (
   input wire logic strap_level,
   input wire logic [3:0] board_shared,
   input wire spmux_pkg::spmux_ctl_type [1:0] board_ctl,
   input wire logic [3:0] shared_pin_out,
   input wire logic [3:0] shared_pin_oe,
   input wire spmux_pkg::spmux_ctl_type [1:0] port_ctl_out,
   input wire spmux_pkg::spmux_ctl_type [1:0] port_ctl_oe,
   output logic serial_config_strap,
   output logic [3:0] shared_pin_in,
   output spmux_pkg::spmux_ctl_type [1:0] port_ctl_in
);
   // Strap resistor on the board; level is only meaningful during reset
   assign serial_config_strap = strap_level;
   // A pin driven by the block shows its value, else the board's level
   assign shared_pin_in = (shared_pin_oe & shared_pin_out) | (~shared_pin_oe & board_shared);
   // Same resolution for the port 0 and 1 clock and sync pins
   assign port_ctl_in = (port_ctl_oe & port_ctl_out) | (~port_ctl_oe & board_ctl);
endmodule // spmux_board

// File: verif/tb_top.sv
// Self-checking bench for the serial port pin multiplexer
`timescale 1ns/1ps

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module tb_top;
   logic clk = 1'b0;
   logic resetn = 1'b1;
   logic strap_level = 1'b0;
   logic [3:0] board_shared = 4'h0;
   spmux_pkg::spmux_ctl_type [1:0] board_ctl = '0;
   logic serial_config_strap;
   spmux_pkg::spmux_emu_type emu_pins = 3'h4;
   spmux_pkg::spmux_ctl_type [1:0] port_ctl_in, port_ctl_out, port_ctl_oe;
   logic [2:0] port_tx_data_out, port_tx_data_oe, eng_rx_data;
   logic [2:0] port_rx_data_in = 3'h0;
   logic [3:0] shared_pin_in, shared_pin_out, shared_pin_oe;
   spmux_pkg::spmux_ctl_type [2:0] eng_ctl_out = '0, eng_ctl_oe = '0, eng_ctl_in;
   logic [2:0] eng_tx_data = 3'h0, eng_tx_data_en = 3'h0;
   spmux_pkg::spmux_ctl_type [2:0] gp_ctl_sel = '0, gp_ctl_out = '0, gp_ctl_oe = '0;
   logic [2:0] gp_tx_data_sel = 3'h0, gp_tx_data_out = 3'h0, gp_tx_data_oe = 3'h0;
   logic gp3_out = 1'b0, gp3_oe = 1'b0, gp5_out = 1'b0, gp5_oe = 1'b0;
   logic general_pin_three_in, general_pin_five_in, uart_rx_value, port2_selected;
   logic uart_tx_value = 1'b1;
   int mismatches = 0;
   int checks_done = 0;

   // 10 MHz clock
   always #50 clk = ~clk;

   spmux_board spmux_board_inst (.strap_level(strap_level),
      .board_shared(board_shared), .board_ctl(board_ctl), .shared_pin_out(shared_pin_out),
      .shared_pin_oe(shared_pin_oe), .port_ctl_out(port_ctl_out), .port_ctl_oe(port_ctl_oe),
      .serial_config_strap(serial_config_strap), .shared_pin_in(shared_pin_in),
      .port_ctl_in(port_ctl_in));

   spmux_top spmux_top_inst (.clk(clk), .resetn(resetn),
      .serial_config_strap(serial_config_strap), .emu_pins(emu_pins),
      .port_ctl_in(port_ctl_in), .port_ctl_out(port_ctl_out), .port_ctl_oe(port_ctl_oe),
      .port_tx_data_out(port_tx_data_out), .port_tx_data_oe(port_tx_data_oe),
      .port_rx_data_in(port_rx_data_in), .shared_pin_in(shared_pin_in),
      .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe),
      .eng_ctl_out(eng_ctl_out), .eng_ctl_oe(eng_ctl_oe), .eng_ctl_in(eng_ctl_in),
      .eng_tx_data(eng_tx_data), .eng_tx_data_en(eng_tx_data_en), .eng_rx_data(eng_rx_data),
      .gp_ctl_sel(gp_ctl_sel), .gp_ctl_out(gp_ctl_out), .gp_ctl_oe(gp_ctl_oe),
      .gp_tx_data_sel(gp_tx_data_sel), .gp_tx_data_out(gp_tx_data_out),
      .gp_tx_data_oe(gp_tx_data_oe), .general_pin_three_out(gp3_out),
      .general_pin_three_oe(gp3_oe), .general_pin_three_in(general_pin_three_in),
      .general_pin_five_out(gp5_out), .general_pin_five_oe(gp5_oe),
      .general_pin_five_in(general_pin_five_in), .uart_tx_value(uart_tx_value),
      .uart_rx_value(uart_rx_value), .port2_selected(port2_selected));

   ////////////////////////////////////////////////////////////////////////////////
   // Inputs change 10 ns after a rising edge (the first reset 10 ns after time zero), so nothing races the edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask

   // Reset with a strap level; two edges fill the strap chain, then two to settle
   task automatic reset_with_strap(input logic strap);
      resetn = 1'b0;
      strap_level = strap;
      #1;
      `CHK(shared_pin_oe, 4'h0)
      `CHK(shared_pin_out, 4'h2)
      `CHK(port_tx_data_oe, 3'h0)
      `CHK(port_ctl_oe, 8'h00)
      step(2);
      resetn = 1'b1;
      step(2);
      `CHK(port2_selected, strap)
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // UART mode: idle pins, general pins three and five, UART receive, strap lock
   task automatic scen_uart_mode();
      reset_with_strap(1'b0);
      `CHK(shared_pin_oe, 4'h2)
      `CHK(shared_pin_out[1], 1'b1)
      `CHK(port_ctl_oe, 8'h00)
      `CHK(port_tx_data_oe, 3'h0)
      gp3_oe = 1'b1;
      gp3_out = 1'b1;
      board_shared = 4'h4;
      strap_level = 1'b1;
      step(1);
      `CHK(shared_pin_oe, 4'h3)
      `CHK(shared_pin_out[0], 1'b1)
      // Pin drive lands one edge later, then two sync stages and the readback flop
      step(3);
      `CHK(general_pin_three_in, 1'b1)
      `CHK(general_pin_five_in, 1'b1)
      `CHK(uart_rx_value, 1'b0)
      `CHK(port2_selected, 1'b0)
      gp5_oe = 1'b1;
      uart_tx_value = 1'b0;
      step(1);
      `CHK(shared_pin_oe, 4'h7)
      `CHK(shared_pin_out[2:1], 2'h0)
   endtask

   // Port 2 mode: shared pins start as inputs, then follow the port 2 engine
   task automatic scen_port2_mode();
      reset_with_strap(1'b1);
      `CHK(shared_pin_oe, 4'h0)
      eng_ctl_oe[2] = 4'hd;
      eng_ctl_out[2] = 4'h9;
      board_shared = 4'h8;
      step(1);
      `CHK(shared_pin_oe, 4'h7)
      `CHK(shared_pin_out[2:0], 3'h6)
      step(2);
      `CHK(eng_ctl_in[2].rx_frame_sync, 1'b1)
      `CHK(general_pin_three_in, 1'b0)
      `CHK(uart_rx_value, 1'b1)
   endtask

   // Ports 0 and 1 by engine and by general purpose override, then OFF mode
   task automatic scen_ports_and_off();
      port_rx_data_in = 3'h5;
      gp_ctl_sel[0] = 4'hf;
      gp_ctl_oe[0] = 4'hf;
      gp_ctl_out[0] = 4'ha;
      eng_ctl_oe[1] = 4'hf;
      eng_ctl_out[1] = 4'h5;
      eng_tx_data_en = 3'h7;
      eng_tx_data = 3'h5;
      step(1);
      `CHK(port_ctl_oe, 8'hff)
      `CHK(port_ctl_out, 8'h5a)
      `CHK(port_tx_data_oe, 3'h7)
      `CHK(port_tx_data_out, 3'h5)
      // Off mode: test reset low, emulation zero high, emulation one low
      emu_pins = 3'h2;
      step(3);
      `CHK(port_ctl_oe, 8'h80)
      `CHK(port_tx_data_oe, 3'h0)
      `CHK(shared_pin_oe, 4'h0)
      // Readbacks still show the pin levels from before OFF mode took hold
      `CHK(eng_rx_data, 3'h5)
      `CHK(eng_ctl_in[1:0], 8'h5a)
      emu_pins = 3'h4;
      step(3);
      `CHK(port_ctl_oe, 8'hff)
      `CHK(shared_pin_oe, 4'h7)
      // Transmit data pins 0 and 1 handed to general purpose, pin 0 floated
      gp_tx_data_sel = 3'h3;
      gp_tx_data_oe = 3'h2;
      gp_tx_data_out = 3'h2;
      step(1);
      `CHK(port_tx_data_oe, 3'h6)
      `CHK(port_tx_data_out, 3'h6)
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run, the only place the run stops
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Main sequence; a second reset in mid-run starts port 2 mode
   // Reset drops after time zero so the asynchronous reset sees a real falling edge
   initial begin
      #10;
      scen_uart_mode();
      scen_port2_mode();
      scen_ports_and_off();
      report_and_stop();
   end
endmodule // tb_top
